// >>> src/acs_top.sv
// Acquisition setting selector: picks the parameter group applied to each capture.
//
// How it works
// - A table of up to ten parameter groups is held, each selectable.
// - Automatic mode applies one group per acquisition, then advances to the next.
// - Reset leaves selection automatic, cycling through the enabled groups.
// - In automatic mode, a new reading cycle starts at the last good group or first enabled.
// - External mode ties each group to its own acquisition sequence.
// - A programmable microsecond delay separates trigger and capture start.
// - Selection works the same whatever reader operating mode is active.
// - Each sequence is started by one single event driven from outside.
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none

module acs_top
    import acs_pkg::*;
#(
    parameter int NGROUPS = ACS_NGROUPS
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite slave.
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [ACS_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [ACS_DATA_W-1:0] s_axi_wdata,
    input  wire logic [ACS_STRB_W-1:0] s_axi_wstrb,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic      [1:0]            s_axi_bresp,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [ACS_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic      [ACS_DATA_W-1:0] s_axi_rdata,
    output logic      [1:0]            s_axi_rresp,
    // Reader side.
    input  wire logic                  acq_trig,
    input  wire logic                  cycle_start,
    input  wire logic                  good_read,
    input  wire logic                  seq_event,
    input  wire logic [ACS_GRP_W-1:0]  seq_sel,
    output logic                       capture_start,
    output acs_capture_s               capture,
    output logic                       busy
);

    // ==========================================================
    // Group search and byte merge helpers
    function automatic logic [ACS_GRP_W-1:0] first_en(input logic [NGROUPS-1:0] mask);
        logic [ACS_GRP_W-1:0] r;
        r = '0;
        for (int i = NGROUPS - 1; i >= 0; i--) begin
            if (mask[i]) begin
                r = ACS_GRP_W'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [ACS_GRP_W-1:0] next_en(input logic [NGROUPS-1:0] mask,
                                                     input logic [ACS_GRP_W-1:0] cur);
        logic [ACS_GRP_W-1:0] r;
        int                   idx;
        r   = cur;
        idx = 0;
        for (int k = NGROUPS - 1; k >= 1; k--) begin
            idx = (int'(cur) + k) % NGROUPS;
            if (mask[idx]) begin
                r = ACS_GRP_W'(idx);
            end
        end
        return r;
    endfunction

    function automatic logic [ACS_DATA_W-1:0] merge(input logic [ACS_DATA_W-1:0] old,
                                                    input logic [ACS_DATA_W-1:0] nw,
                                                    input logic [ACS_STRB_W-1:0] strb);
        logic [ACS_DATA_W-1:0] r;
        r = old;
        for (int b = 0; b < ACS_STRB_W; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // State declarations
    logic                   aw_held_reg, aw_held_next;
    logic [ACS_ADDR_W-1:0]  aw_addr_reg, aw_addr_next;
    logic                   w_held_reg, w_held_next;
    logic [ACS_DATA_W-1:0]  w_data_reg, w_data_next;
    logic [ACS_STRB_W-1:0]  w_strb_reg, w_strb_next;
    logic                   bvalid_reg, bvalid_next;
    logic [1:0]             bresp_reg, bresp_next;
    acs_cfg_s               cfg_reg, cfg_next;
    logic                   mem_wr_en;

    acs_rd_state_e          rd_state_reg, rd_state_next;
    logic [ACS_ADDR_W-1:0]  ar_addr_reg, ar_addr_next;
    logic [ACS_DATA_W-1:0]  rdata_reg, rdata_next;
    logic [1:0]             rresp_reg, rresp_next;

    acs_state_e             state_reg, state_next;
    logic [ACS_GRP_W-1:0]   cur_reg, cur_next;
    logic [ACS_GRP_W-1:0]   sel_reg, sel_next;
    logic [ACS_GRP_W-1:0]   last_good_reg, last_good_next;
    logic [ACS_DELAY_W-1:0] us_left_reg, us_left_next;
    logic [ACS_SUB_W-1:0]   sub_reg, sub_next;
    logic                   fire_reg, fire_next;
    acs_capture_s           cap_reg, cap_next;

    logic                   mem_rd_en;
    logic [ACS_GRP_W-1:0]   mem_rd_addr;
    logic [ACS_PARAM_W-1:0] mem_rd_data;
    logic                   axi_mem_rd;
    logic [ACS_DATA_W-1:0]  rd_word;
    logic                   rd_mapped;
    logic                   wr_table;

    localparam logic [ACS_SUB_W-1:0] SUB_LAST = ACS_SUB_W'(ACS_CYC_PER_US - 1);

    // ==========================================================
    // Write channel and configuration registers
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign wr_table      = (aw_addr_reg >= ACS_OFF_TABLE) && (aw_addr_reg < ACS_OFF_TABLE_END);

    always_comb begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next  = w_held_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        cfg_next     = cfg_reg;
        mem_wr_en    = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (aw_held_reg && w_held_reg && !bvalid_reg) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = ACS_RESP_OKAY;
            if (aw_addr_reg == ACS_OFF_CTRL) begin
                if (w_strb_reg[0]) begin
                    cfg_next.mode       = acs_mode_e'(w_data_reg[ACS_CTRL_MODE_BIT]);
                    cfg_next.start_last = w_data_reg[ACS_CTRL_LAST_BIT];
                end
            end else if (aw_addr_reg == ACS_OFF_ENABLE) begin
                cfg_next.enable = NGROUPS'(merge(ACS_DATA_W'(cfg_reg.enable),
                                                 w_data_reg, w_strb_reg));
            end else if (aw_addr_reg == ACS_OFF_DELAY) begin
                cfg_next.delay_us = ACS_DELAY_W'(merge(ACS_DATA_W'(cfg_reg.delay_us),
                                                       w_data_reg, w_strb_reg));
            end else if (aw_addr_reg == ACS_OFF_STATUS) begin
                bresp_next = ACS_RESP_OKAY;
            end else if (wr_table) begin
                mem_wr_en = 1'b1;
            end else begin
                bresp_next = ACS_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_held_reg  <= 1'b0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= ACS_RESP_OKAY;
            cfg_reg     <= '{delay_us: ACS_DELAY_RST, enable: ACS_ENABLE_RST,
                             start_last: 1'b0, mode: ACS_MODE_AUTO};
        end else begin
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg  <= w_held_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            cfg_reg     <= cfg_next;
        end
    end

    // ==========================================================
    // Read channel
    assign s_axi_arready = (rd_state_reg == ACS_RD_IDLE);
    assign s_axi_rvalid  = (rd_state_reg == ACS_RD_RESP);
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    // The capture engine owns the table read port while fetching; bus reads wait a cycle.
    assign axi_mem_rd    = (rd_state_reg == ACS_RD_MEM) && (state_reg != ACS_ST_FETCH);

    always_comb begin
        rd_word   = '0;
        rd_mapped = 1'b1;
        if (ar_addr_reg == ACS_OFF_CTRL) begin
            rd_word[ACS_CTRL_MODE_BIT] = cfg_reg.mode;
            rd_word[ACS_CTRL_LAST_BIT] = cfg_reg.start_last;
        end else if (ar_addr_reg == ACS_OFF_ENABLE) begin
            rd_word[NGROUPS-1:0] = cfg_reg.enable;
        end else if (ar_addr_reg == ACS_OFF_DELAY) begin
            rd_word[ACS_DELAY_W-1:0] = cfg_reg.delay_us;
        end else if (ar_addr_reg == ACS_OFF_STATUS) begin
            rd_word[ACS_STAT_CUR_LSB +: ACS_GRP_W]  = cur_reg;
            rd_word[ACS_STAT_LAST_LSB +: ACS_GRP_W] = last_good_reg;
            rd_word[ACS_STAT_BUSY_BIT]              = (state_reg != ACS_ST_IDLE);
        end else begin
            rd_mapped = 1'b0;
        end
    end

    always_comb begin
        rd_state_next = rd_state_reg;
        ar_addr_next  = ar_addr_reg;
        rdata_next    = rdata_reg;
        rresp_next    = rresp_reg;
        case (rd_state_reg)
            ACS_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    ar_addr_next = s_axi_araddr;
                    if ((s_axi_araddr >= ACS_OFF_TABLE) && (s_axi_araddr < ACS_OFF_TABLE_END)) begin
                        rd_state_next = ACS_RD_MEM;
                    end else begin
                        rd_state_next = ACS_RD_CAP;
                    end
                end
            end
            ACS_RD_MEM: begin
                if (axi_mem_rd) begin
                    rd_state_next = ACS_RD_CAP;
                end
            end
            ACS_RD_CAP: begin
                rd_state_next = ACS_RD_RESP;
                rresp_next    = ACS_RESP_OKAY;
                if ((ar_addr_reg >= ACS_OFF_TABLE) && (ar_addr_reg < ACS_OFF_TABLE_END)) begin
                    rdata_next = mem_rd_data;
                end else begin
                    rdata_next = rd_word;
                    if (!rd_mapped) begin
                        rresp_next = ACS_RESP_SLVERR;
                    end
                end
            end
            ACS_RD_RESP: begin
                if (s_axi_rready) begin
                    rd_state_next = ACS_RD_IDLE;
                end
            end
            default: begin
                rd_state_next = ACS_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_reg <= ACS_RD_IDLE;
            ar_addr_reg  <= '0;
            rdata_reg    <= '0;
            rresp_reg    <= ACS_RESP_OKAY;
        end else begin
            rd_state_reg <= rd_state_next;
            ar_addr_reg  <= ar_addr_next;
            rdata_reg    <= rdata_next;
            rresp_reg    <= rresp_next;
        end
    end

    // ==========================================================
    // Capture engine
    assign mem_rd_en     = (state_reg == ACS_ST_FETCH) || axi_mem_rd;
    assign mem_rd_addr   = (state_reg == ACS_ST_FETCH) ? sel_reg :
                           ACS_GRP_W'(ar_addr_reg[ACS_ADDR_W-1:ACS_WORD_LSB] -
                                      ACS_OFF_TABLE[ACS_ADDR_W-1:ACS_WORD_LSB]);
    assign capture_start = fire_reg;
    assign capture       = cap_reg;
    assign busy          = (state_reg != ACS_ST_IDLE);

    // The engine ignores any reader operating mode; only trigger, cycle, good-read and sequence events steer it.
    always_comb begin
        state_next     = state_reg;
        cur_next       = cur_reg;
        sel_next       = sel_reg;
        last_good_next = last_good_reg;
        us_left_next   = us_left_reg;
        sub_next       = sub_reg;
        fire_next      = 1'b0;
        cap_next       = cap_reg;
        case (state_reg)
            ACS_ST_IDLE: begin
                if (acq_trig) begin
                    sel_next     = cur_reg;
                    us_left_next = cfg_reg.delay_us;
                    sub_next     = '0;
                    if (cfg_reg.delay_us == '0) begin
                        state_next = ACS_ST_FETCH;
                    end else begin
                        state_next = ACS_ST_DELAY;
                    end
                end
            end
            ACS_ST_DELAY: begin
                if (sub_reg == SUB_LAST) begin
                    sub_next     = '0;
                    us_left_next = us_left_reg - 1'b1;
                    if (us_left_reg == ACS_DELAY_W'(1)) begin
                        state_next = ACS_ST_FETCH;
                    end
                end else begin
                    sub_next = sub_reg + 1'b1;
                end
            end
            ACS_ST_FETCH: begin
                state_next = ACS_ST_FIRE;
            end
            ACS_ST_FIRE: begin
                fire_next       = 1'b1;
                cap_next.group  = sel_reg;
                cap_next.params = mem_rd_data;
                state_next      = ACS_ST_IDLE;
                if (cfg_reg.mode == ACS_MODE_AUTO) begin
                    cur_next = next_en(cfg_reg.enable, sel_reg);
                end
            end
            default: begin
                state_next = ACS_ST_IDLE;
            end
        endcase
        if (good_read) begin
            last_good_next = cap_reg.group;
        end
        if (cfg_reg.mode == ACS_MODE_AUTO) begin
            if (cycle_start) begin
                cur_next = cfg_reg.start_last ? last_good_next : first_en(cfg_reg.enable);
            end
        end else if (seq_event && (int'(seq_sel) < NGROUPS) && cfg_reg.enable[seq_sel]) begin
            cur_next = seq_sel;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg     <= ACS_ST_IDLE;
            cur_reg       <= '0;
            sel_reg       <= '0;
            last_good_reg <= '0;
            us_left_reg   <= '0;
            sub_reg       <= '0;
            fire_reg      <= 1'b0;
            cap_reg       <= '0;
        end else begin
            state_reg     <= state_next;
            cur_reg       <= cur_next;
            sel_reg       <= sel_next;
            last_good_reg <= last_good_next;
            us_left_reg   <= us_left_next;
            sub_reg       <= sub_next;
            fire_reg      <= fire_next;
            cap_reg       <= cap_next;
        end
    end

    // ==========================================================
    // Parameter group table
    acs_param_mem #(
        .DEPTH  (NGROUPS),
        .DATA_W (ACS_PARAM_W),
        .ADDR_W (ACS_GRP_W)
    ) u_mem (
        .aclk    (aclk),
        .wr_en   (mem_wr_en),
        .wr_addr (ACS_GRP_W'(aw_addr_reg[ACS_ADDR_W-1:ACS_WORD_LSB] -
                             ACS_OFF_TABLE[ACS_ADDR_W-1:ACS_WORD_LSB])),
        .wr_data (w_data_reg),
        .wr_strb (w_strb_reg),
        .rd_en   (mem_rd_en),
        .rd_addr (mem_rd_addr),
        .rd_data (mem_rd_data)
    );

endmodule // acs_top

`default_nettype wire

// >>> inc/acs_pkg.sv
// Package of constants, types and the register map for the acquisition setting selector.
`default_nettype none

package acs_pkg;

    // ==========================================================
    // Table geometry
    localparam int ACS_NGROUPS  = 10;
    localparam int ACS_GRP_W    = 4;
    localparam int ACS_PARAM_W  = 32;
    localparam int ACS_DELAY_W  = 16;
    localparam int ACS_ADDR_W   = 12;
    localparam int ACS_DATA_W   = 32;
    localparam int ACS_STRB_W   = ACS_DATA_W / 8;

    // ==========================================================
    // Timing
    localparam int ACS_CLK_PERIOD_NS = 10;
    localparam int ACS_US_NS         = 1000;
    localparam int ACS_CYC_PER_US    = (ACS_US_NS + ACS_CLK_PERIOD_NS - 1) / ACS_CLK_PERIOD_NS;
    localparam int ACS_SUB_W         = 7;

    // ==========================================================
    // Register byte offsets
    localparam logic [ACS_ADDR_W-1:0] ACS_OFF_CTRL       = 12'h000;
    localparam logic [ACS_ADDR_W-1:0] ACS_OFF_ENABLE     = 12'h004;
    localparam logic [ACS_ADDR_W-1:0] ACS_OFF_DELAY      = 12'h008;
    localparam logic [ACS_ADDR_W-1:0] ACS_OFF_STATUS     = 12'h00c;
    localparam logic [ACS_ADDR_W-1:0] ACS_OFF_TABLE      = 12'h040;
    localparam logic [ACS_ADDR_W-1:0] ACS_OFF_TABLE_END  = 12'h068;
    localparam int                    ACS_WORD_LSB       = 2;

    // ==========================================================
    // Field positions
    localparam int ACS_CTRL_MODE_BIT   = 0;
    localparam int ACS_CTRL_LAST_BIT   = 1;
    localparam int ACS_STAT_CUR_LSB    = 0;
    localparam int ACS_STAT_LAST_LSB   = 8;
    localparam int ACS_STAT_BUSY_BIT   = 16;

    // ==========================================================
    // Reset values
    localparam logic [ACS_NGROUPS-1:0] ACS_ENABLE_RST = 10'h001;
    localparam logic [ACS_DELAY_W-1:0] ACS_DELAY_RST  = 16'h0000;

    // ==========================================================
    // Bus responses
    localparam logic [1:0] ACS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ACS_RESP_SLVERR = 2'h2;

    // ==========================================================
    // Types
    typedef enum logic {
        ACS_MODE_AUTO = 1'b0,
        ACS_MODE_EXT  = 1'b1
    } acs_mode_e;

    typedef enum logic [3:0] {
        ACS_ST_IDLE  = 4'h1,
        ACS_ST_DELAY = 4'h2,
        ACS_ST_FETCH = 4'h4,
        ACS_ST_FIRE  = 4'h8
    } acs_state_e;

    typedef enum logic [3:0] {
        ACS_RD_IDLE = 4'h1,
        ACS_RD_MEM  = 4'h2,
        ACS_RD_CAP  = 4'h4,
        ACS_RD_RESP = 4'h8
    } acs_rd_state_e;

    typedef struct packed {
        logic [ACS_DELAY_W-1:0] delay_us;
        logic [ACS_NGROUPS-1:0] enable;
        logic                   start_last;
        acs_mode_e              mode;
    } acs_cfg_s;

    typedef struct packed {
        logic [ACS_GRP_W-1:0]   group;
        logic [ACS_PARAM_W-1:0] params;
    } acs_capture_s;

endpackage : acs_pkg

`default_nettype wire

// >>> src/acs_param_mem.sv
// Parameter group table with byte-enabled write and registered read data.
`default_nettype none

module acs_param_mem
    import acs_pkg::*;
#(
    parameter int DEPTH  = ACS_NGROUPS,
    parameter int DATA_W = ACS_PARAM_W,
    parameter int ADDR_W = ACS_GRP_W
) (
    input  wire logic              aclk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [DATA_W/8-1:0] wr_strb,
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data
);

    // ==========================================================
    // Storage
    logic [DATA_W-1:0] mem [DEPTH];

    always_ff @(posedge aclk) begin
        if (wr_en && (int'(wr_addr) < DEPTH)) begin
            for (int b = 0; b < DATA_W / 8; b++) begin
                if (wr_strb[b]) begin
                    mem[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
                end
            end
        end
        if (rd_en) begin
            rd_data <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
        end
    end

endmodule // acs_param_mem

`default_nettype wire

// >>> dv/acs_top_monitor.sv
// Concurrent checks on the capture side of the acquisition setting selector.
`default_nettype none

module acs_top_monitor
    import acs_pkg::*;
#(
    parameter int NGROUPS = ACS_NGROUPS
) (
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire logic         acq_trig,
    input wire logic         busy,
    input wire logic         capture_start,
    input wire acs_capture_s capture
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    trig_take_a: assert property (acq_trig && !busy |=> busy)
        else $error("trigger taken while idle did not raise busy");
    fire_bound_a: assert property (acq_trig && !busy |-> ##[3:1000] capture_start)
        else $error("capture did not start in time");
    fire_early_a: assert property (acq_trig && !busy |=> !capture_start [*2])
        else $error("capture started too early");
    fire_pulse_a: assert property (capture_start |=> !capture_start)
        else $error("capture start longer than one cycle");
    busy_drop_a: assert property (capture_start |-> !busy && $past(busy))
        else $error("busy wrong around capture start");
    group_range_a: assert property (capture_start |-> capture.group < NGROUPS)
        else $error("capture group out of range");
    capture_hold_a: assert property (!capture_start |-> $stable(capture))
        else $error("capture changed without capture start");
    reset_idle_a: assert property (disable iff (1'b0) !aresetn |=> !busy && !capture_start)
        else $error("outputs not idle after reset");
    cover property (capture_start);
    cover property (acq_trig && busy);
    cover property (capture_start && acq_trig);
endmodule // acs_top_monitor

bind acs_top acs_top_monitor #(.NGROUPS(NGROUPS)) u_acs_top_monitor (
    .aclk, .aresetn, .acq_trig, .busy, .capture_start, .capture);

`default_nettype wire

// >>> dv/acs_trig_src.sv
// Model of the trigger and setting-select event source.
`default_nettype none

module acs_trig_src
    import acs_pkg::*;
(
    input  wire logic                 aclk,
    output var  logic                 acq_trig,
    output var  logic                 cycle_start,
    output var  logic                 good_read,
    output var  logic                 seq_event,
    output var  logic [ACS_GRP_W-1:0] seq_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {acq_trig, cycle_start, good_read, seq_event, seq_sel} = '0;
    end
    // Each sequence gets exactly one single-cycle event; the index is inverted once released.
    task automatic pulse(input int k, input logic [ACS_GRP_W-1:0] s);
        @(posedge aclk);
        acq_trig    <= (k == 0);
        cycle_start <= (k == 1);
        good_read   <= (k == 2);
        seq_event   <= (k == 3);
        seq_sel     <= s;
        @(posedge aclk);
        {acq_trig, cycle_start, good_read, seq_event} <= '0;
        seq_sel <= ~s;
    endtask
endmodule // acs_trig_src

`default_nettype wire

// >>> dv/acs_top_bench.sv
// Self-checking bench of the acquisition setting selector.
`default_nettype none

module acs_top_bench
    import acs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, acq_trig, cycle_start, good_read, seq_event, capture_start, busy;
    logic [ACS_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [ACS_DATA_W-1:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]            s_axi_bresp, s_axi_rresp, r;
    logic [ACS_GRP_W-1:0]  seq_sel;
    acs_capture_s          capture;
    int                    fail_count, compares;

    acs_top u_acs_top (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .acq_trig, .cycle_start, .good_read, .seq_event,
        .seq_sel, .capture_start, .capture, .busy);
    acs_trig_src u_acs_trig_src (.aclk, .acq_trig, .cycle_start, .good_read, .seq_event,
        .seq_sel);

    // ==========================================================
    // Tasks
    task automatic give_verdict();
        if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [ACS_ADDR_W-1:0] a, input logic [31:0] v);
        logic pa, pw, t;
        pa = 1'b1; pw = 1'b1; t = 1'b0;
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_bready <= 1'b1;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        while (!t) begin
            @(negedge aclk);
            t = s_axi_bvalid; pa = pa && !s_axi_awready; pw = pw && !s_axi_wready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (!t) begin
                s_axi_awvalid <= pa; s_axi_wvalid <= pw;
            end
        end
    endtask
    task automatic rd(input logic [ACS_ADDR_W-1:0] a);
        logic p, t;
        p = 1'b1; t = 1'b0;
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        while (!t) begin
            @(negedge aclk);
            t = s_axi_rvalid; d = s_axi_rdata; r = s_axi_rresp; p = p && !s_axi_arready;
            @(posedge aclk);
            if (!t) begin
                s_axi_arvalid <= p;
            end
        end
    endtask
    task automatic acq(input logic [ACS_GRP_W-1:0] g, input int cyc);
        int n;
        n = 0;
        u_acs_trig_src.pulse(0, '0);
        do begin
            @(negedge aclk);
            n++;
        end while (capture_start !== 1'b1);
        chk("capture latency", 36'(n), 36'(cyc));
        chk("capture group", 36'(capture.group), 36'(g));
        chk("capture params", 36'(capture.params), {4'h0, 32'ha5000000 | 32'(g)});
        @(posedge aclk);
    endtask

    // ==========================================================
    // Clock, watchdog and tests
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        fail_count = 0; compares = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ACS_OFF_CTRL); chk("ctrl reset", 36'(d), 36'h0);
        rd(ACS_OFF_ENABLE); chk("enable reset", 36'(d), 36'(ACS_ENABLE_RST));
        rd(12'h020); chk("unmapped resp", 36'(r), 36'(ACS_RESP_SLVERR));
        wr(12'h020, 32'h0); chk("unmapped wresp", 36'(r), 36'(ACS_RESP_SLVERR));
        for (int i = 0; i < ACS_NGROUPS; i++) wr(ACS_OFF_TABLE + 12'(4 * i), 32'ha5000000 | i);
        rd(ACS_OFF_TABLE + 12'h024); chk("table word", 36'(d), 36'ha5000009);
        wr(ACS_OFF_ENABLE, 32'h224);
        u_acs_trig_src.pulse(1, '0);
        acq(4'h2, 3); acq(4'h5, 3);
        u_acs_trig_src.pulse(2, '0);
        acq(4'h9, 3); acq(4'h2, 3);
        wr(ACS_OFF_CTRL, 32'h2);
        u_acs_trig_src.pulse(1, '0);
        acq(4'h5, 3);
        wr(ACS_OFF_CTRL, 32'h0);
        u_acs_trig_src.pulse(1, '0);
        acq(4'h2, 3);
        wr(ACS_OFF_CTRL, 32'h1);
        u_acs_trig_src.pulse(3, 4'h9);
        acq(4'h9, 3); acq(4'h9, 3);
        u_acs_trig_src.pulse(3, 4'hc);
        u_acs_trig_src.pulse(1, '0);
        acq(4'h9, 3);
        wr(ACS_OFF_DELAY, 32'h1);
        acq(4'h9, 103);
        give_verdict();
    end
endmodule // acs_top_bench

`default_nettype wire
